// ---- shared/acf_pkg.sv ----
package acf_pkg;
  // Register map over AHB-Lite (byte addresses)
  localparam logic [7:0] CTRL0_ADDR = 8'h00;
  localparam logic [7:0] CTRL1_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] DATA_ADDR = 8'h0c;
  localparam logic [7:0] SAMPLE_ADDR = 8'h10;
  // First control word fields
  localparam int MODE_BIT = 1;
  localparam int CHSEL_LSB = 3;
  localparam int DIFF_LSB = 5;
  // Second control word fields
  localparam int FRST_BIT = 1;
  localparam int TRIG_LSB = 2;
  localparam int TWOS_BIT = 7;
  localparam logic [9:0] CTRL0_RESET = 10'h000;
  localparam logic [9:0] CTRL1_RESET = 10'h000;
  // Sizes
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int SMP_W = 10;
  localparam logic [9:0] MID_CODE = 10'h200;
  // Pipeline latency in conversion clocks
  localparam logic [4:0] PIPE_CYCLES = 5'h07;
  // Internal oscillator: conversion period
  localparam int CLK_MHZ = 40;
  localparam int TCONV_NS = 167;
  localparam int OSC_DIV = (TCONV_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ACF_IDLE = 3'b001,
    ACF_CONV = 3'b010,
    ACF_DRAIN = 3'b100
  } acf_state_t;
endpackage

// ---- verilog/acf_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mode bit one set selects single mode
// - Start strobe fall holds and converts channels
// - Single mode timed by internal oscillator
// - Flag asserts when trigger level reached
// - Up to four channels sampled together in single mode
// - Flag delay is pipeline plus n periods
// - Oscillator stops in continuous mode
// - Mode bit zero converts from external clock
// - Each conversion clock rise after the pipeline fills writes one value
// - Channels written in fixed autoscan order
// - Samples coded binary or twos complement
// - Single-ended binary codes 3ff 200 000
// - Single-ended twos codes 1ff 000 200
// - Differential binary codes 3ff 200 000
// - Differential twos codes 1ff 000 200
// - Circular store of sixteen values, auto-written
// - Read, write and trigger pointers kept
// - Trigger met when written count equals level
// - Block starts with first autoscan channel
// - Continuous first flag delayed seven plus level
// - Clock pin acts as strobe in single mode
// - Level one gives low pulse per sample
module acf_top
  import acf_pkg::*;
(
  input wire logic clk, // System clock 40 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic conversion_clock_input, // Conversion clock or start strobe pin
  input wire logic [39:0] sample_in, // Raw offset-binary result per channel
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  output logic block_available_flag_n, // Block available, active low
  output logic osc_run // Internal oscillator running
);

  logic [9:0] first_control_word;
  logic [9:0] second_control_word;
  logic [9:0] mem [DEPTH];
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] trig_ptr;
  logic [4:0] fill;
  logic [4:0] hold_cnt;
  logic [1:0] scan_idx;
  logic [39:0] held;
  logic [7:0] osc_cnt;
  logic osc_tick;
  logic [2:0] pin_sync;
  logic pin_rise;
  logic pin_fall;
  logic wr_en;
  logic [9:0] wr_data;
  logic a_wr;
  logic a_rd;
  logic [7:0] a_addr;
  logic rd_pop;
  logic fifo_rst;
  logic single_mode;
  logic [2:0] nchan;
  logic [4:0] block_threshold;
  acf_state_t state;

  // Count of selected channels from the channel field
  function automatic logic [2:0] chan_count(input logic [1:0] sel);
    chan_count = {1'b0, sel} + 3'h1;
  endfunction

  // Block size from trigger field, channel-dependent
  function automatic logic [4:0] level_of(input logic [1:0] trig, input logic [2:0] n);
    case (trig)
      2'h0: level_of = (n == 3'h1) ? 5'h01 : {2'h0, n};
      2'h1: level_of = (n == 3'h3) ? 5'h06 : 5'h04;
      2'h2: level_of = (n == 3'h3) ? 5'h09 : 5'h08;
      default: level_of = (n == 3'h3) ? 5'h0c : ((n == 3'h1) ? 5'h0e : 5'h0c);
    endcase
  endfunction

  // Output coding of one raw offset-binary result
  function automatic logic [9:0] encode(input logic [9:0] raw, input logic twos);
    encode = twos ? (raw ^ MID_CODE) : raw;
  endfunction

  assign single_mode = first_control_word[MODE_BIT];
  assign nchan = chan_count(first_control_word[CHSEL_LSB +: 2]);
  assign block_threshold = level_of(second_control_word[TRIG_LSB +: 2], nchan);
  assign a_rd = hsel && htrans[1] && hready && !hwrite;
  assign fifo_rst = a_wr && (a_addr == CTRL1_ADDR) && hwdata[FRST_BIT];

  // Two-stage synchroniser on the pin, edge from stages two and three
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], conversion_clock_input};
    end
  end
  assign pin_rise = pin_sync[1] && !pin_sync[2];
  assign pin_fall = !pin_sync[1] && pin_sync[2];

  // Internal conversion oscillator, gated off in continuous mode
  always_ff @(posedge clk) begin
    if (!rstn || !single_mode || state == ACF_IDLE) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else if (osc_cnt == 8'(OSC_DIV - 1)) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
      osc_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_run <= 1'b0;
    end else begin
      osc_run <= single_mode && (state != ACF_IDLE);
    end
  end

  // Conversion sequencer: pipeline wait, then autoscan writes
  always_ff @(posedge clk) begin
    if (!rstn || fifo_rst) begin
      state <= ACF_IDLE;
      scan_idx <= 2'h0;
      hold_cnt <= 5'h00;
      held <= 40'h0;
    end else begin
      case (state)
        ACF_IDLE: begin
          if (single_mode && pin_fall) begin
            held <= sample_in;
            hold_cnt <= 5'h00;
            scan_idx <= 2'h0;
            state <= ACF_CONV;
          end else if (!single_mode && pin_rise) begin
            if (hold_cnt != PIPE_CYCLES) begin
              hold_cnt <= hold_cnt + 5'h01;
            end else begin
              scan_idx <= (scan_idx == 2'(nchan - 3'h1)) ? 2'h0 : scan_idx + 2'h1;
            end
          end
        end
        ACF_CONV: begin
          if (osc_tick) begin
            if (hold_cnt == PIPE_CYCLES - 5'h01) begin
              state <= ACF_DRAIN;
            end else begin
              hold_cnt <= hold_cnt + 5'h01;
            end
          end
        end
        ACF_DRAIN: begin
          if (osc_tick) begin
            if (scan_idx == 2'(nchan - 3'h1)) begin
              state <= ACF_IDLE;
              hold_cnt <= 5'h00;
              scan_idx <= 2'h0;
            end else begin
              scan_idx <= scan_idx + 2'h1;
            end
          end
        end
        default: state <= ACF_IDLE;
      endcase
    end
  end

  // Write strobe: one result per period once the pipeline is full
  always_comb begin
    wr_en = 1'b0;
    wr_data = encode(sample_in[scan_idx*10 +: 10], second_control_word[TWOS_BIT]);
    if (state == ACF_DRAIN && osc_tick) begin
      wr_en = 1'b1;
      wr_data = encode(held[scan_idx*10 +: 10], second_control_word[TWOS_BIT]);
    end else if (state == ACF_IDLE && !single_mode && pin_rise && hold_cnt == PIPE_CYCLES) begin
      wr_en = 1'b1;
    end
  end

  // Circular store and its pointers
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ptr + 4'h1] <= wr_data;
    end
  end

  // Read pointer: the location that is read next
  always_ff @(posedge clk) begin
    if (!rstn || fifo_rst) begin
      rd_ptr <= 4'h0;
    end else if (rd_pop && fill != 5'h00) begin
      rd_ptr <= rd_ptr + 4'h1;
    end
  end

  // Write pointer: the last written location, one behind read after reset
  always_ff @(posedge clk) begin
    if (!rstn || fifo_rst) begin
      wr_ptr <= 4'hf;
    end else if (wr_en) begin
      wr_ptr <= wr_ptr + 4'h1;
    end
  end

  // Trigger pointer: location that completes the current block
  always_ff @(posedge clk) begin
    if (!rstn || fifo_rst) begin
      trig_ptr <= 4'h0;
    end else if (wr_en && fill == block_threshold - 5'h01) begin
      trig_ptr <= wr_ptr + 4'h1;
    end
  end

  // Fill count; saturates so an overrun overwrites the oldest word
  always_ff @(posedge clk) begin
    if (!rstn || fifo_rst) begin
      fill <= 5'h00;
    end else if (wr_en && !(rd_pop && fill != 5'h00) && fill != 5'(DEPTH)) begin
      fill <= fill + 5'h01;
    end else if (!wr_en && rd_pop && fill != 5'h00) begin
      fill <= fill - 5'h01;
    end
  end

  // Block flag: low once a full block is stored; pulses for level one
  always_ff @(posedge clk) begin
    if (!rstn || fifo_rst) begin
      block_available_flag_n <= 1'b1;
    end else if (block_threshold == 5'h01) begin
      block_available_flag_n <= !(wr_en);
    end else if (wr_en && fill + 5'h01 >= block_threshold) begin
      block_available_flag_n <= 1'b0;
    end else if (rd_pop && fill - 5'h01 < block_threshold) begin
      block_available_flag_n <= 1'b1;
    end
  end

  // AHB-Lite slave: address phase capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      a_wr <= 1'b0;
    end else begin
      a_wr <= hsel && htrans[1] && hready && hwrite;
    end
  end

  // Address kept for the write data phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      a_addr <= 8'h00;
    end else begin
      a_addr <= haddr[7:0];
    end
  end
  assign rd_pop = a_rd && (haddr[7:0] == DATA_ADDR);

  // Control words written in the data phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      first_control_word <= CTRL0_RESET;
    end else if (a_wr && a_addr == CTRL0_ADDR) begin
      first_control_word <= hwdata[9:0];
    end
  end

  // Second word; the buffer reset bit clears itself
  always_ff @(posedge clk) begin
    if (!rstn) begin
      second_control_word <= CTRL1_RESET;
    end else if (a_wr && a_addr == CTRL1_ADDR) begin
      second_control_word <= {hwdata[9:2], 2'h0};
    end
  end

  // Read data registered during the address phase, zero-wait answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (a_rd) begin
        case (haddr[7:0])
          CTRL0_ADDR: begin
            hrdata <= {22'h0, first_control_word};
          end
          CTRL1_ADDR: begin
            hrdata <= {22'h0, second_control_word};
          end
          STATUS_ADDR: begin
            hrdata <= {21'h0, state, fill, 1'b0, !block_available_flag_n, osc_run};
          end
          DATA_ADDR: begin
            hrdata <= (fill != 5'h00) ? {22'h0, mem[rd_ptr]} : 32'h0;
          end
          SAMPLE_ADDR: begin
            hrdata <= {27'h0, block_threshold};
          end
          default: begin
            hrdata <= 32'h0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/acf_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module acf_top_properties (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic conversion_clock_input, // Pin
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic block_available_flag_n, // Flag
  input wire logic osc_run // Oscillator
);
  logic [7:0] pin_hist;
  logic [3:0] acc_hist;
  logic [7:0] osc_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Recent pin levels, accepted transfers, oscillator run length
  always_ff @(posedge clk) begin
    pin_hist <= {pin_hist[6:0], conversion_clock_input};
    acc_hist <= {acc_hist[2:0], hsel & htrans[1] & hready};
    osc_cnt <= osc_run ? osc_cnt + 8'h01 : 8'h00;
  end
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_data_hold: assert property (!$stable(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite))
    else $error("read data moved without a read");
  a_flag_rise: assert property ($rose(block_available_flag_n) |-> |acc_hist || $past(block_available_flag_n, 2))
    else $error("flag released without bus access");
  a_flag_fall: assert property ($fell(block_available_flag_n) |-> |pin_hist || $past(osc_run))
    else $error("flag set without conversion");
  a_osc_start: assert property ($rose(osc_run) |-> !conversion_clock_input && |pin_hist)
    else $error("oscillator started without strobe fall");
  a_osc_min_run: assert property ($rose(osc_run) |-> osc_run [*8])
    else $error("oscillator stopped too soon");
  a_osc_bounded: assert property (osc_cnt < 8'hc8)
    else $error("oscillator runs too long");
  a_reset_idle: assert property ($rose(rstn) |-> block_available_flag_n && !osc_run && hrdata == 32'h0)
    else $error("outputs not idle after reset");
endmodule
bind acf_top acf_top_properties acf_top_properties_i (.clk, .rstn, .conversion_clock_input,
  .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .block_available_flag_n, .osc_run);
`default_nettype wire

// ---- tb/acf_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module acf_src (
  input wire logic clk, // Clock
  output logic conversion_clock_input, // Conversion clock or strobe
  output logic [39:0] sample_in // Channel k in bits [10k+9:10k]
);
  initial begin
    conversion_clock_input = 1'b0;
    sample_in = 40'h0;
  end
  // Pulses 4 high, 4 low; pin rests low between bursts
  task automatic pulse(input int n);
    repeat (n) begin
      conversion_clock_input <= 1'b1;
      repeat (4) @(posedge clk);
      conversion_clock_input <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/acf_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module acf_top_tb
  import acf_pkg::*;
;
  logic clk, rstn, hsel, hwrite, pin, hreadyout, hresp, flag_n, osc_run;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [39:0] smp;
  logic [9:0] exp4 [4] = '{10'h000, 10'h200, 10'h3ff, 10'h155};
  int error_cnt = 0;
  int compares = 0;
  acf_top acf_top_i (.clk(clk), .rstn(rstn), .conversion_clock_input(pin), .sample_in(smp),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .block_available_flag_n(flag_n), .osc_run(osc_run));
  acf_src acf_src_i (.clk(clk), .conversion_clock_input(pin), .sample_in(smp));
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  // One single AHB transfer, address then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic flag(input logic e);
    repeat (2) @(posedge clk);
    chk("flag", {31'h0, e}, {31'h0, flag_n});
  endtask
  task automatic final_report;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("idle", 32'h2, {30'h0, flag_n, osc_run});
    rdc("unmapped", 8'h20, 32'h0);
    // Continuous, one channel, level 4
    wr(CTRL0_ADDR, 32'h0);
    wr(CTRL1_ADDR, 32'h6);
    rdc("level", SAMPLE_ADDR, 32'h4);
    acf_src_i.sample_in <= 40'h3ff;
    acf_src_i.pulse(10);
    flag(1'b1);
    acf_src_i.pulse(1);
    flag(1'b0);
    chk("osc", 32'h0, {31'h0, osc_run});
    for (int i = 0; i < 4; i++)
      rdc("bin", DATA_ADDR, 32'h3ff);
    flag(1'b1);
    acf_src_i.pulse(4);
    flag(1'b0);
    wr(CTRL1_ADDR, 32'h6);
    flag(1'b1);
    // Continuous, two differential channels, twos complement
    wr(CTRL0_ADDR, 32'h68);
    wr(CTRL1_ADDR, 32'h82);
    acf_src_i.sample_in <= 40'h00000803ff;
    acf_src_i.pulse(9);
    flag(1'b0);
    acf_src_i.pulse(3);
    for (int i = 0; i < 4; i++)
      rdc("twos", DATA_ADDR, i[0] ? 32'h0 : 32'h1ff);
    // Single mode, four channels started by strobe fall
    wr(CTRL0_ADDR, 32'h7a);
    wr(CTRL1_ADDR, 32'h2);
    acf_src_i.sample_in <= {exp4[3], exp4[2], exp4[1], exp4[0]};
    acf_src_i.pulse(1);
    @(posedge clk);
    chk("osc", 32'h1, {31'h0, osc_run});
    repeat (54) @(posedge clk);
    chk("early", 32'h1, {31'h0, flag_n});
    for (int i = 0; i < 100 && flag_n !== 1'b0; i++)
      @(posedge clk);
    chk("late", 32'h0, {31'h0, flag_n});
    for (int i = 0; i < 4; i++)
      rdc("single", DATA_ADDR, {22'h0, exp4[i]});
    final_report();
  end
endmodule
`default_nettype wire
